// file: rtl/output_compare_pkg.sv
// Functional notes
// - The timebase select bit picks the second timer when 1, the first timer when 0.
// - The mode decides whether one compare value or both are checked against the count.
// - The pin changes level when the count equals the relevant compare value.
// - Mode 000 disables the channel, raises no interrupt and hands the pin to the port latch.
// - Mode 001 starts low, goes high on a match and interrupts on that rising edge.
// - Mode 010 starts high, goes low on a match and interrupts on that falling edge.
// - Mode 011 keeps the present level, toggles on each match and interrupts on both edges.
// - Mode 100 starts low, makes one pulse and interrupts on its falling edge.
// - Mode 101 starts low, makes repeated pulses and interrupts on each falling edge.
// - Mode 110 is PWM without fault, no interrupt, start level 1 unless primary is zero.
// - Mode 111 is PWM with fault, interrupting on a falling edge of the fault input.
// - A read-only fault flag is set on a PWM fault and cleared by any write to the control register.
// - With idle halt set the compare matches and the PWM rollover freeze while the processor idles.
// - Unimplemented control bits 15 to 14 and 12 to 5 read as zero.
package output_compare_pkg;
   localparam logic [1:0] ADDR_CONTROL = 2'h0;
   localparam logic [1:0] ADDR_PRIMARY = 2'h1;
   localparam logic [1:0] ADDR_SECONDARY = 2'h2;
   localparam logic [1:0] ADDR_IRQ_STATUS = 2'h3;
   localparam logic [1:0] ADDR_IRQ_ENABLE = 2'h0;
   localparam logic [1:0] ADDR_IRQ_CLEAR = 2'h3;
   localparam int BIT_IDLE_HALT = 13;
   localparam int BIT_FAULT_FLAG = 4;
   localparam int BIT_TIMEBASE = 3;
   localparam logic [15:0] CONTROL_WRITE_MASK = 16'h200F;
   localparam logic [15:0] CONTROL_RESET = 16'h0000;
   localparam int IRQ_BIT_COMPARE = 0;
   localparam int IRQ_BIT_FAULT = 1;
   localparam logic [1:0] IRQ_RESET = 2'h0;
   typedef enum logic [2:0] {
      MODE_OFF = 3'h0,
      MODE_RISE_ONCE = 3'h1,
      MODE_FALL_ONCE = 3'h2,
      MODE_TOGGLE = 3'h3,
      MODE_DELAYED_ONE = 3'h4,
      MODE_PULSES = 3'h5,
      MODE_PWM = 3'h6,
      MODE_PWM_FAULT = 3'h7
   } compare_mode_t;
endpackage

// file: rtl/output_compare_channel.sv
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
module output_compare_channel #(
   parameter int WIDTH = 16
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // register port; the extra select bit reaches interrupt enable/clear
   input wire logic [1:0] regAddr,
   input wire logic regHigh,
   input wire logic [15:0] regWriteData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [15:0] regReadData,
   // time bases and their period rollover pulses
   input wire logic [WIDTH-1:0] firstTimer,
   input wire logic firstTimerRollover,
   input wire logic [WIDTH-1:0] secondTimer,
   input wire logic secondTimerRollover,
   // system
   input wire logic cpuIdle,
   input wire logic portLatch,
   input wire logic firstFaultInput_n,
   // pin and interrupt
   output logic compareOutputPin,
   output logic interrupt
);
   typedef struct packed {
      logic [15:0] control;
      logic [WIDTH-1:0] primary;
      logic [WIDTH-1:0] secondary;
      logic [1:0] irqStatus;
      logic [1:0] irqEnable;
      logic pin;
      logic done;
      logic faultSeen;
      logic lastFault_n;
      logic [15:0] readData;
   } state_t;

   state_t state;
   state_t next_state;
   output_compare_pkg::compare_mode_t mode;
   logic [WIDTH-1:0] count;
   logic rollover;
   logic running;
   logic matchPrimary;
   logic matchSecondary;
   logic nextPin;
   logic faultFall;
   logic modeWrite;

   assign mode = output_compare_pkg::compare_mode_t'(state.control[2:0]);
   // time base select
   assign count = state.control[output_compare_pkg::BIT_TIMEBASE] ?
                  secondTimer : firstTimer;
   assign rollover = state.control[output_compare_pkg::BIT_TIMEBASE] ?
                     secondTimerRollover : firstTimerRollover;
   // freeze in idle only when asked to
   assign running = !(state.control[output_compare_pkg::BIT_IDLE_HALT]
                      && cpuIdle);
   assign matchPrimary = running && (count == state.primary);
   assign matchSecondary = running && (count == state.secondary);
   assign faultFall = state.lastFault_n && !firstFaultInput_n;
   assign modeWrite = regWrite && !regHigh &&
                      regAddr == output_compare_pkg::ADDR_CONTROL;

   always_comb begin
      next_state = state;
      nextPin = state.pin;
      next_state.lastFault_n = firstFaultInput_n;
      next_state.readData = 16'h0000;
      if (regRead) begin
         if (regHigh) begin
            next_state.readData = (regAddr ==
               output_compare_pkg::ADDR_IRQ_ENABLE) ?
               {14'h0000, state.irqEnable} : 16'h0000;
         end else begin
            unique case (regAddr)
               output_compare_pkg::ADDR_CONTROL:
                  next_state.readData = state.control;
               output_compare_pkg::ADDR_PRIMARY:
                  next_state.readData = 16'(state.primary);
               output_compare_pkg::ADDR_SECONDARY:
                  next_state.readData = 16'(state.secondary);
               output_compare_pkg::ADDR_IRQ_STATUS:
                  next_state.readData = {14'h0000, state.irqStatus};
            endcase
         end
      end
      // pin sequencing
      unique case (mode)
         output_compare_pkg::MODE_OFF: begin
            nextPin = portLatch;
         end
         output_compare_pkg::MODE_RISE_ONCE: begin
            if (matchPrimary) begin
               nextPin = 1'b1;
            end
         end
         output_compare_pkg::MODE_FALL_ONCE: begin
            if (matchPrimary) begin
               nextPin = 1'b0;
            end
         end
         output_compare_pkg::MODE_TOGGLE: begin
            if (matchPrimary) begin
               nextPin = !state.pin;
            end
         end
         output_compare_pkg::MODE_DELAYED_ONE,
         output_compare_pkg::MODE_PULSES: begin
            // a single pulse stops after its falling edge
            if (matchSecondary && state.pin) begin
               nextPin = 1'b0;
               next_state.done = (mode ==
                  output_compare_pkg::MODE_DELAYED_ONE);
            end else if (matchPrimary && !state.done) begin
               nextPin = 1'b1;
            end
         end
         output_compare_pkg::MODE_PWM,
         output_compare_pkg::MODE_PWM_FAULT: begin
            // duty zero keeps the pin low all period
            if (running && rollover) begin
               nextPin = (state.primary != '0);
            end
            if (matchPrimary) begin
               nextPin = 1'b0;
            end
            if (mode == output_compare_pkg::MODE_PWM_FAULT) begin
               if (faultFall) begin
                  next_state.faultSeen = 1'b1;
               end
               if (next_state.faultSeen) begin
                  nextPin = 1'b0;
               end
            end
         end
      endcase
      // interrupt sources; set wins over clear
      if (regWrite && regHigh &&
          regAddr == output_compare_pkg::ADDR_IRQ_CLEAR) begin
         next_state.irqStatus = state.irqStatus & ~regWriteData[1:0];
      end
      if (regWrite && regHigh &&
          regAddr == output_compare_pkg::ADDR_IRQ_ENABLE) begin
         next_state.irqEnable = regWriteData[1:0];
      end
      unique case (mode)
         output_compare_pkg::MODE_RISE_ONCE: begin
            if (nextPin && !state.pin) begin
               next_state.irqStatus[output_compare_pkg::IRQ_BIT_COMPARE] =
                  1'b1;
            end
         end
         output_compare_pkg::MODE_FALL_ONCE,
         output_compare_pkg::MODE_DELAYED_ONE,
         output_compare_pkg::MODE_PULSES: begin
            if (!nextPin && state.pin) begin
               next_state.irqStatus[output_compare_pkg::IRQ_BIT_COMPARE] =
                  1'b1;
            end
         end
         output_compare_pkg::MODE_TOGGLE: begin
            if (nextPin != state.pin) begin
               next_state.irqStatus[output_compare_pkg::IRQ_BIT_COMPARE] =
                  1'b1;
            end
         end
         output_compare_pkg::MODE_PWM_FAULT: begin
            if (faultFall) begin
               next_state.irqStatus[output_compare_pkg::IRQ_BIT_FAULT] =
                  1'b1;
            end
         end
         default: begin
            // off and plain PWM raise nothing
         end
      endcase
      next_state.pin = nextPin;
      // control writes; fault flag is not writable
      if (regWrite && !regHigh) begin
         unique case (regAddr)
            output_compare_pkg::ADDR_CONTROL:
               next_state.control = regWriteData &
                  output_compare_pkg::CONTROL_WRITE_MASK;
            output_compare_pkg::ADDR_PRIMARY:
               next_state.primary = regWriteData[WIDTH-1:0];
            output_compare_pkg::ADDR_SECONDARY:
               next_state.secondary = regWriteData[WIDTH-1:0];
            default: begin
            end
         endcase
      end
      if (modeWrite) begin
         // entering a mode sets its start level
         next_state.done = 1'b0;
         next_state.faultSeen = 1'b0;
         unique case (regWriteData[2:0])
            3'h1, 3'h4, 3'h5: next_state.pin = 1'b0;
            3'h2: next_state.pin = 1'b1;
            3'h6, 3'h7: next_state.pin =
               (next_state.primary != '0);
            default: begin
            end
         endcase
      end
      next_state.control[output_compare_pkg::BIT_FAULT_FLAG] =
         next_state.faultSeen;
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign regReadData = state.readData;
   assign compareOutputPin = state.pin;
   assign interrupt = |(state.irqStatus & state.irqEnable);

   a_fault_forces_low: assert property (@(posedge clock) disable iff (!reset_n)
      (mode == output_compare_pkg::MODE_PWM_FAULT && state.faultSeen &&
       !modeWrite) |=> !compareOutputPin)
      else $error("pin not low after fault");
   a_fault_sets_flag: assert property (@(posedge clock) disable iff (!reset_n)
      (mode == output_compare_pkg::MODE_PWM_FAULT && faultFall && !modeWrite)
      |=> state.control[4] && state.irqStatus[1])
      else $error("fault not flagged");
   a_off_follows_latch: assert property (@(posedge clock) disable iff
      (!reset_n) (mode == output_compare_pkg::MODE_OFF && !modeWrite)
      |=> compareOutputPin == $past(portLatch))
      else $error("disabled pin not from latch");
   a_rise_on_match: assert property (@(posedge clock) disable iff (!reset_n)
      (mode == output_compare_pkg::MODE_RISE_ONCE && matchPrimary &&
       !compareOutputPin && !modeWrite) |=> compareOutputPin &&
       state.irqStatus[0])
      else $error("no rise on match");
   a_fall_on_match: assert property (@(posedge clock) disable iff (!reset_n)
      (mode == output_compare_pkg::MODE_FALL_ONCE && matchPrimary &&
       !modeWrite) |=> !compareOutputPin)
      else $error("no fall on match");
   a_toggle_on_match: assert property (@(posedge clock) disable iff
      (!reset_n) (mode == output_compare_pkg::MODE_TOGGLE && matchPrimary &&
       !modeWrite) |=> compareOutputPin != $past(compareOutputPin))
      else $error("no toggle on match");
   a_pulse_secondary: assert property (@(posedge clock) disable iff
      (!reset_n) (mode == output_compare_pkg::MODE_PULSES && matchSecondary
      && compareOutputPin && !modeWrite) |=> !compareOutputPin)
      else $error("pulse not ended");
   a_idle_freezes: assert property (@(posedge clock) disable iff (!reset_n)
      (!running && mode == output_compare_pkg::MODE_TOGGLE && !modeWrite)
      |=> $stable(compareOutputPin))
      else $error("pin moved in idle");
   a_reserved_zero: assert property (@(posedge clock) disable iff (!reset_n)
      (regRead && !regHigh && regAddr == output_compare_pkg::ADDR_CONTROL)
      |=> (regReadData & 16'hDFE0) == 16'h0000)
      else $error("reserved bits set");

   // modes without an interrupt source must leave the status alone
   a_off_no_irq: assert property (
      @(posedge clock) disable iff (!reset_n)
      (mode == output_compare_pkg::MODE_OFF && !regWrite)
      |=> $stable(state.irqStatus))
      else $error("status moved while off");

   a_pwm_no_irq: assert property (
      @(posedge clock) disable iff (!reset_n)
      (mode == output_compare_pkg::MODE_PWM && !regWrite)
      |=> $stable(state.irqStatus))
      else $error("status moved in plain pwm");

   a_rise_start_low: assert property (
      @(posedge clock) disable iff (!reset_n)
      (modeWrite && regWriteData[2:0] == 3'h1)
      |=> !compareOutputPin)
      else $error("rise mode not started low");

   a_fall_start_high: assert property (
      @(posedge clock) disable iff (!reset_n)
      (modeWrite && regWriteData[2:0] == 3'h2)
      |=> compareOutputPin)
      else $error("fall mode not started high");

   a_fall_irq: assert property (
      @(posedge clock) disable iff (!reset_n)
      (mode == output_compare_pkg::MODE_FALL_ONCE && matchPrimary &&
       compareOutputPin && !modeWrite) |=> state.irqStatus[0])
      else $error("no interrupt on fall");

   a_toggle_irq: assert property (
      @(posedge clock) disable iff (!reset_n)
      (mode == output_compare_pkg::MODE_TOGGLE && matchPrimary &&
       !modeWrite) |=> state.irqStatus[0])
      else $error("no interrupt on toggle");

   a_single_stops: assert property (
      @(posedge clock) disable iff (!reset_n)
      (mode == output_compare_pkg::MODE_DELAYED_ONE && state.done &&
       !modeWrite) |=> !compareOutputPin)
      else $error("second pulse in single mode");

   a_pulse_irq: assert property (
      @(posedge clock) disable iff (!reset_n)
      (mode == output_compare_pkg::MODE_PULSES && matchSecondary &&
       compareOutputPin && !modeWrite) |=> state.irqStatus[0])
      else $error("no interrupt on pulse end");

   a_pulse_rise: assert property (
      @(posedge clock) disable iff (!reset_n)
      (mode == output_compare_pkg::MODE_PULSES && matchPrimary &&
       !matchSecondary && !modeWrite) |=> compareOutputPin)
      else $error("pulse not started");

   a_pwm_start_level: assert property (
      @(posedge clock) disable iff (!reset_n)
      (modeWrite && regWriteData[2:0] == 3'h6)
      |=> compareOutputPin == (state.primary != '0))
      else $error("pwm start level wrong");

   // a zero duty would be contradicted at once, so it is left out here
   a_rollover_raises: assert property (
      @(posedge clock) disable iff (!reset_n)
      (mode == output_compare_pkg::MODE_PWM && running && rollover &&
       !matchPrimary && state.primary != '0 && !regWrite)
      |=> compareOutputPin)
      else $error("pin not raised at rollover");

   a_flag_readonly: assert property (
      @(posedge clock) disable iff (!reset_n)
      (regWrite && !regHigh &&
       regAddr == output_compare_pkg::ADDR_CONTROL)
      |=> !state.control[output_compare_pkg::BIT_FAULT_FLAG])
      else $error("fault flag kept over control write");

   a_flag_mode_only: assert property (
      @(posedge clock) disable iff (!reset_n)
      (mode != output_compare_pkg::MODE_PWM_FAULT) |-> !state.faultSeen)
      else $error("fault flag outside fault mode");

   c_pwm_rollover: cover property (@(posedge clock)
      mode == output_compare_pkg::MODE_PWM && running && rollover);
   c_toggle: cover property (@(posedge clock)
      mode == output_compare_pkg::MODE_TOGGLE && matchPrimary);
   c_pulse_done: cover property (@(posedge clock) state.done);
   c_fault: cover property (@(posedge clock) state.faultSeen);
   c_irq: cover property (@(posedge clock) interrupt);
endmodule // output_compare_channel

// file: testbench/pin_monitor.sv
`timescale 1ns/1ps
module pin_monitor (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // observed pin
   input wire logic pin,
   // edge counts
   output int rises,
   output int falls
);
   logic last;
   // a pure load: it never drives the pin back, only counts its edges
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         last <= 1'b0;
         rises <= 0;
         falls <= 0;
      end else begin
         last <= pin;
         if (pin && !last) rises <= rises + 1;
         if (!pin && last) falls <= falls + 1;
      end
   end
endmodule // pin_monitor

// file: testbench/output_compare_channel_tb.sv
`timescale 1ns/1ps
module output_compare_channel_tb;
   localparam int PERIOD = 32;
   localparam logic [1:0] CTL = output_compare_pkg::ADDR_CONTROL;
   localparam logic [1:0] PRI = output_compare_pkg::ADDR_PRIMARY;
   localparam logic [1:0] SEC = output_compare_pkg::ADDR_SECONDARY;
   localparam logic [1:0] STS = output_compare_pkg::ADDR_IRQ_STATUS;
   localparam logic [1:0] IEN = output_compare_pkg::ADDR_IRQ_ENABLE;
   localparam logic [1:0] ICL = output_compare_pkg::ADDR_IRQ_CLEAR;
   logic clock, reset_n, regHigh, regWrite, regRead, run, tsel, cpuIdle;
   logic portLatch, firstFaultInput_n, compareOutputPin, interrupt;
   logic firstTimerRollover, secondTimerRollover;
   logic [1:0] regAddr;
   logic [15:0] regWriteData, regReadData, cnt, rd, firstTimer, secondTimer;
   int failures, n_tests, rises, falls, f0;
   output_compare_channel u_output_compare_channel (.clock(clock),
      .reset_n(reset_n), .regAddr(regAddr), .regHigh(regHigh),
      .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
      .regReadData(regReadData), .firstTimer(firstTimer),
      .firstTimerRollover(firstTimerRollover), .secondTimer(secondTimer),
      .secondTimerRollover(secondTimerRollover), .cpuIdle(cpuIdle),
      .portLatch(portLatch), .firstFaultInput_n(firstFaultInput_n),
      .compareOutputPin(compareOutputPin), .interrupt(interrupt));
   pin_monitor u_pin_monitor (.clock(clock), .reset_n(reset_n),
      .pin(compareOutputPin), .rises(rises), .falls(falls));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // the count rests at zero while stopped, so control writes never race it
   always @(posedge clock) begin
      if (!run) cnt <= 16'h0000;
      else cnt <= (cnt == PERIOD - 1) ? 16'h0000 : cnt + 16'h0001;
      firstTimer <= tsel ? 16'h0000 : cnt;
      secondTimer <= tsel ? cnt : 16'h0000;
      firstTimerRollover <= run && !tsel && cnt == PERIOD - 1;
      secondTimerRollover <= run && tsel && cnt == PERIOD - 1;
   end
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic hi, input logic [1:0] a, input logic [15:0] d);
      @(posedge clock);
      regHigh <= hi;
      regAddr <= a;
      regWriteData <= d;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask
   task rchk(input logic hi, input logic [1:0] a, input logic [15:0] e);
      @(posedge clock);
      regHigh <= hi;
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      #1 rd = regReadData;
      chk(rd, e);
   endtask
   task tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task go(input int n);
      @(posedge clock);
      run <= 1'b1;
      repeat (n) @(posedge clock);
      run <= 1'b0;
      tick(3);
   endtask
   task pchk(input logic e);
      chk({15'h0000, compareOutputPin}, {15'h0000, e});
   endtask
   task setm(input logic [15:0] c);
      wr(1'b0, CTL, c);
      tick(2);
   endtask
   task tend(input string name);
      wr(1'b1, ICL, 16'h0003);
      $display("test %s done", name);
   endtask
   task test_done;
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      #100000;
      failures++;
      test_done;
   end
   initial begin
      {regHigh, regWrite, regRead, run, tsel, cpuIdle, portLatch} = 7'h00;
      {regAddr, regWriteData} = 18'h00000;
      firstFaultInput_n = 1'b1;
      reset_n = 1'b0;
      repeat (6) @(posedge clock);
      reset_n <= 1'b1;
      rchk(1'b0, CTL, 16'h0000);
      rchk(1'b0, STS, 16'h0000);
      wr(1'b0, CTL, 16'hFFF8);
      rchk(1'b0, CTL, 16'h2008);
      rchk(1'b1, 2'h1, 16'h0000);
      setm(16'h0000);
      portLatch <= 1'b1;
      tick(2);
      pchk(1'b1);
      portLatch <= 1'b0;
      tick(2);
      pchk(1'b0);
      wr(1'b1, IEN, 16'h0003);
      wr(1'b0, PRI, 16'h000A);
      wr(1'b0, SEC, 16'h0014);
      tend("registers");
      setm(16'h0001);
      pchk(1'b0);
      go(20);
      pchk(1'b1);
      chk({15'h0000, interrupt}, 16'h0001);
      rchk(1'b0, STS, 16'h0001);
      tend("rise once");
      tick(1);
      chk({15'h0000, interrupt}, 16'h0000);
      setm(16'h0002);
      pchk(1'b1);
      go(20);
      pchk(1'b0);
      rchk(1'b0, STS, 16'h0001);
      tend("fall once");
      setm(16'h0003);
      pchk(1'b0);
      f0 = falls;
      go(20);
      pchk(1'b1);
      go(20);
      chk(16'(falls - f0), 16'h0001);
      rchk(1'b0, STS, 16'h0001);
      tend("toggle");
      wr(1'b0, PRI, 16'h0005);
      wr(1'b0, SEC, 16'h000F);
      setm(16'h0004);
      pchk(1'b0);
      go(12);
      pchk(1'b1);
      go(20);
      pchk(1'b0);
      rchk(1'b0, STS, 16'h0001);
      wr(1'b1, ICL, 16'h0003);
      go(20);
      rchk(1'b0, STS, 16'h0000);
      tend("single pulse");
      setm(16'h0005);
      f0 = falls;
      go(20);
      go(20);
      chk(16'(falls - f0), 16'h0002);
      chk(16'(rises - falls), 16'h0000);
      rchk(1'b0, STS, 16'h0001);
      tend("pulses");
      setm(16'h0006);
      pchk(1'b1);
      go(12);
      pchk(1'b0);
      go(36);
      pchk(1'b1);
      rchk(1'b0, STS, 16'h0000);
      tend("pwm");
      setm(16'h0007);
      pchk(1'b1);
      firstFaultInput_n <= 1'b0;
      tick(3);
      pchk(1'b0);
      rchk(1'b0, CTL, 16'h0017);
      rchk(1'b0, STS, 16'h0002);
      firstFaultInput_n <= 1'b1;
      tend("pwm fault");
      setm(16'h2001);
      cpuIdle <= 1'b1;
      go(20);
      pchk(1'b0);
      cpuIdle <= 1'b0;
      go(20);
      pchk(1'b1);
      tend("idle halt");
      tsel <= 1'b1;
      setm(16'h0001);
      go(20);
      pchk(1'b0);
      setm(16'h0009);
      go(20);
      pchk(1'b1);
      tend("timebase");
      test_done;
   end
endmodule // output_compare_channel_tb
